// *** verilog/pbe_pkg.sv ***
/*
  Package for the byte parity error handler: word layout, parity
  functions, register offsets, field positions and reset values.
  Assumes a 16-bit datapath split into two bytes, each with its own bit.
*/
package pbe_pkg;

  // Bus and datapath widths.
  localparam int AXI_AW  = 8;
  localparam int BYTE_W  = 8;
  localparam int WORD_W  = 16;
  localparam int ROUT_W  = 4;
  localparam int TRAP_W  = 16;

  // A stored word: each byte preceded by its own parity bit, which sits just above it.
  typedef struct packed {
    logic              parHi;
    logic [BYTE_W-1:0] hi;
    logic              parLo;
    logic [BYTE_W-1:0] lo;
  } pbe_word_t;

  // Self-test sequencer states, Gray coded along idle, launch, wait.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LAUNCH = 2'b01,
    ST_WAIT   = 2'b11
  } pbe_state_t;

  // Register byte offsets.
  localparam logic [AXI_AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_MASK   = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_FLAGS  = 8'h0c;
  localparam logic [AXI_AW-1:0] OFF_STATE  = 8'h10;
  localparam logic [AXI_AW-1:0] OFF_ERRW   = 8'h14;

  // Field positions.
  localparam int CTRL_CHECK  = 0;
  localparam int CTRL_START  = 1;
  localparam int ST_MEMTRAP  = 0;
  localparam int ST_FAULT    = 1;
  localparam int ST_PASS     = 2;
  localparam int FL_MEM      = 0;
  localparam int FL_PROC     = 1;
  localparam int EV_W        = 3;
  localparam int FL_W        = 2;

  // Reset values and bus answers.
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam logic [1:0]      RESP_OK  = 2'h0;
  localparam logic [1:0]      RESP_ERR = 2'h2;

  // Odd parity: the bit makes the count of ones in byte plus bit odd.
  function automatic pbe_word_t pbe_gen(input logic [WORD_W-1:0] d);
    pbe_word_t w;
    w.hi    = d[WORD_W-1:BYTE_W];
    w.lo    = d[BYTE_W-1:0];
    w.parHi = ~^d[WORD_W-1:BYTE_W];
    w.parLo = ~^d[BYTE_W-1:0];
    return w;
  endfunction : pbe_gen

  // One bit per byte, high where that byte fails its check.
  function automatic logic [1:0] pbe_bad(input pbe_word_t w);
    return {~^{w.parHi, w.hi}, ~^{w.parLo, w.lo}};
  endfunction : pbe_bad

endpackage : pbe_pkg

// *** verilog/pbe_parity_handler.sv ***
/*
  Byte parity generation and checking for memory, processor and I/O
  transfers, the check-mode error response, and the self-test sequencer.
  Assumes one clock, inputs synchronous to it, an AXI4-Lite master that
  keeps one write and one read outstanding, and a microverification
  engine that answers each start pulse with one done pulse.
//
// Contract
// - Each 16-bit word is held as two bytes with one parity bit per byte.
// - Parity is generated on every memory write and checked on every read.
// - In check mode a memory parity error interrupts and traps to a fixed address.
// - Outside check mode a memory parity error only sets a testable flag.
// - Parity is generated and checked on all processor and I/O transfers.
// - In check mode with self-test fitted a processor error starts self-test.
// - Without self-test a processor error sets a flag and starts nothing.
// - Self-test starts on processor error, master clear or software request.
// - A failing routine is shown on the panel and rerun, stalling the machine.
// - When the rerun routine passes, normal execution resumes by itself.
// - Both bytes of a word are generated or checked in a single cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module pbe_parity_handler #(
  parameter bit                   SELF_TEST_FITTED = 1'b1,
  parameter logic [3:0]           NUM_ROUTINES     = 4'd8,
  parameter logic [15:0]          TRAP_ADDR        = 16'h0000
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       masterClear,
  // Memory write and read paths.
  input  wire logic                       memWrValid,
  input  wire logic [pbe_pkg::WORD_W-1:0] memWrData,
  output var  pbe_pkg::pbe_word_t         memWrWord,
  input  wire logic                       memRdValid,
  input  wire pbe_pkg::pbe_word_t         memRdWord,
  output logic [pbe_pkg::WORD_W-1:0]      memRdData,
  output logic                            trapReq,
  output logic [pbe_pkg::TRAP_W-1:0]      trapAddr,
  // Processor and I/O transfers.
  input  wire logic                       xferValid,
  input  wire pbe_pkg::pbe_word_t         xferWord,
  input  wire logic [pbe_pkg::WORD_W-1:0] xferGenData,
  output var  pbe_pkg::pbe_word_t         xferGenWord,
  // Microverification engine and panel.
  output logic                            stStart,
  output logic [pbe_pkg::ROUT_W-1:0]      stRoutine,
  input  wire logic                       stDone,
  input  wire logic                       stFail,
  output logic [pbe_pkg::ROUT_W-1:0]      panelId,
  output logic                            cpuHold,
  output logic                            irq,
  // AXI4-Lite slave.
  input  wire logic [pbe_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [pbe_pkg::AXI_AW-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready
);
  import pbe_pkg::*;

  logic              awHeld, wHeld, doWrite, wrLow, checkMode, stalled;
  logic [AXI_AW-1:0] awAddrQ, wrAddr;
  logic [31:0]       wDataQ, wrData, rdMux;
  logic [3:0]        wStrbQ;
  logic [EV_W-1:0]   status, mask, evSet, stClr;
  logic [FL_W-1:0]   flags, flSet, flClr;
  logic [17:0]       errWord;
  pbe_state_t        state;
  logic [1:0]        memBad, xferBad;
  logic              memErr, procErr, swStart, trigger, lastRoutine;
  logic              faultEv, passEv, rdHit;

  // Both bytes are checked in parallel, so an error is known in-cycle.
  assign memBad  = pbe_bad(memRdWord);
  assign xferBad = pbe_bad(xferWord);
  assign memErr  = memRdValid & (|memBad);
  assign procErr = xferValid & (|xferBad);

  // Generated words are registered so the parity bits meet the data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memWrWord   <= '0;
      xferGenWord <= '0;
      memRdData   <= '0;
    end else begin
      if (memWrValid) begin
        memWrWord <= pbe_gen(memWrData);
      end
      xferGenWord <= pbe_gen(xferGenData);
      if (memRdValid) begin
        memRdData <= {memRdWord.hi, memRdWord.lo};
      end
    end
  end

  // The trap fires only in check mode; the address is a fixed constant.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trapReq  <= 1'b0;
      trapAddr <= '0;
    end else begin
      trapReq  <= memErr & checkMode;
      trapAddr <= TRAP_ADDR;
    end
  end

  // The last failing word is kept for software diagnosis.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errWord <= '0;
    end else if (memErr) begin
      errWord <= memRdWord;
    end else if (procErr) begin
      errWord <= xferWord;
    end
  end

  // Self-test entry; requests arriving while busy are dropped.
  assign swStart = doWrite & (wrAddr == OFF_CTRL) & wrLow & wrData[CTRL_START];
  assign trigger = (procErr & checkMode & SELF_TEST_FITTED)
                 | masterClear | swStart;
  assign lastRoutine = ({1'b0, stRoutine} + 5'd1) == {1'b0, NUM_ROUTINES};
  assign faultEv = (state == ST_WAIT) & stDone & stFail & ~stalled;
  assign passEv  = (state == ST_WAIT) & stDone & ~stFail
                 & (stalled | lastRoutine);
  assign stStart = (state == ST_LAUNCH);
  assign cpuHold = (state != ST_IDLE);

  // Sequencer: a failing routine is relaunched until it passes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      stRoutine <= '0;
      stalled   <= 1'b0;
      panelId   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            stRoutine <= '0;
            state     <= ST_LAUNCH;
          end
        end
        ST_LAUNCH: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (stDone) begin
            if (stFail) begin
              stalled <= 1'b1;
              panelId <= stRoutine;
              state   <= ST_LAUNCH;
            end else if (stalled) begin
              stalled <= 1'b0;
              state   <= ST_IDLE;
            end else if (lastRoutine) begin
              state <= ST_IDLE;
            end else begin
              stRoutine <= stRoutine + 4'd1;
              state     <= ST_LAUNCH;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // AXI write: address and data are latched separately, in any order.
  assign awready = ~awHeld & ~bvalid;
  assign wready  = ~wHeld & ~bvalid;
  assign doWrite = (awHeld | (awvalid & awready))
                 & (wHeld | (wvalid & wready));
  assign wrAddr  = awHeld ? awAddrQ : awaddr;
  assign wrData  = wHeld ? wDataQ : wdata;
  assign wrLow   = wHeld ? wStrbQ[0] : wstrb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= '0;
      wStrbQ  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
    end else begin
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (wrAddr == OFF_CTRL || wrAddr == OFF_STATUS
                || wrAddr == OFF_MASK || wrAddr == OFF_FLAGS
                || wrAddr == OFF_STATE || wrAddr == OFF_ERRW)
                ? RESP_OK : RESP_ERR;
      end else begin
        if (awvalid & awready) begin
          awHeld  <= 1'b1;
          awAddrQ <= awaddr;
        end
        if (wvalid & wready) begin
          wHeld  <= 1'b1;
          wDataQ <= wdata;
          wStrbQ <= wstrb;
        end
        if (bvalid & bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  // Control and mask registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      checkMode <= 1'b0;
      mask      <= MASK_RST;
    end else if (doWrite & wrLow) begin
      if (wrAddr == OFF_CTRL) begin
        checkMode <= wrData[CTRL_CHECK];
      end
      if (wrAddr == OFF_MASK) begin
        mask <= wrData[EV_W-1:0];
      end
    end
  end

  // Sticky bits clear on a written one; a new event wins over the clear.
  assign evSet = {passEv, faultEv, memErr & checkMode};
  assign flSet = {procErr, memErr & ~checkMode};
  assign stClr = (doWrite & wrLow & (wrAddr == OFF_STATUS))
               ? wrData[EV_W-1:0] : '0;
  assign flClr = (doWrite & wrLow & (wrAddr == OFF_FLAGS))
               ? wrData[FL_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      flags  <= '0;
    end else begin
      status <= (status & ~stClr) | evSet;
      if (masterClear) begin
        flags <= flSet;
      end else begin
        flags <= (flags & ~flClr) | flSet;
      end
    end
  end

  // Only masked status events (trap, fault, pass) reach the line; flags never interrupt.
  assign irq = |(status & mask);

  // AXI read path, unmapped addresses answer SLVERR with zero data.
  always_comb begin
    rdMux = '0;
    rdHit = 1'b1;
    case (araddr)
      OFF_CTRL:   rdMux = {31'h0, checkMode};
      OFF_STATUS: rdMux = {29'h0, status};
      OFF_MASK:   rdMux = {29'h0, mask};
      OFF_FLAGS:  rdMux = {30'h0, flags};
      OFF_STATE:  rdMux = {20'h0, panelId, stRoutine, 1'b0, state, stalled};
      OFF_ERRW:   rdMux = {14'h0, errWord};
      default:    rdHit = 1'b0;
    endcase
  end

  assign arready = ~rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OK;
    end else if (arvalid & arready) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rdHit ? RESP_OK : RESP_ERR;
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks kept beside the logic they guard.
  property p_wrgen;
    @(posedge clk) disable iff (rst)
      memWrValid |=> memWrWord == pbe_gen($past(memWrData));
  endproperty
  a_wrgen: assert property (p_wrgen) else $error("bad write parity");

  property p_trap;
    @(posedge clk) disable iff (rst)
      (memErr && checkMode) |=> trapReq && trapAddr == TRAP_ADDR
        ##0 status[ST_MEMTRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("no trap on error");

  property p_notrap;
    @(posedge clk) disable iff (rst)
      (memErr && !checkMode) |=> !trapReq && flags[FL_MEM];
  endproperty
  a_notrap: assert property (p_notrap) else $error("flag path wrong");

  property p_proc;
    @(posedge clk) disable iff (rst)
      procErr |=> flags[FL_PROC];
  endproperty
  a_proc: assert property (p_proc) else $error("proc flag missing");

  property p_enter;
    @(posedge clk) disable iff (rst)
      (state == ST_IDLE && trigger) |=> state == ST_LAUNCH ##1 stStart == 1'b0;
  endproperty
  a_enter: assert property (p_enter) else $error("self-test not begun");

  property p_nofit;
    @(posedge clk) disable iff (rst)
      (state == ST_IDLE && procErr && !(checkMode && SELF_TEST_FITTED)
        && !masterClear && !swStart)
        |=> state == ST_IDLE && flags[FL_PROC];
  endproperty
  a_nofit: assert property (p_nofit) else $error("self-test began");

  property p_stall;
    @(posedge clk) disable iff (rst)
      (state == ST_WAIT && stDone && stFail)
        |=> stalled && panelId == $past(stRoutine) && stStart;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not shown");

  property p_resume;
    @(posedge clk) disable iff (rst)
      (state == ST_WAIT && stDone && !stFail && stalled)
        |=> !stalled && !cpuHold;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (flags[FL_MEM] && !masterClear && !flClr[FL_MEM]) |=> flags[FL_MEM];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");

endmodule : pbe_parity_handler

`default_nettype wire

// *** tb/pbe_engine_model.sv ***
/*
  Model of the microverification engine: answers each start pulse with
  one done pulse a few cycles later, failing a chosen routine on demand.
  Assumes start pulses last one cycle and are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pbe_engine_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stStart,
  input  wire logic [3:0] stRoutine,
  input  wire logic       failNow,
  input  wire logic [3:0] failAt,
  output logic            stDone,
  output logic            stFail
);
  logic [2:0] cnt;
  logic       busy;
  logic [3:0] rout;

  // The fail line wanders outside done, so a stale value is never seen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
      busy <= 1'b0;
      rout <= 4'h0;
      stDone <= 1'b0;
      stFail <= 1'b0;
    end else begin
      stDone <= 1'b0;
      stFail <= ~stFail;
      if (stStart) begin
        busy <= 1'b1;
        cnt <= 3'h3;
        rout <= stRoutine;
      end else if (busy && cnt == 3'h0) begin
        busy <= 1'b0;
        stDone <= 1'b1;
        stFail <= failNow && rout == failAt;
      end else if (busy) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule : pbe_engine_model

`default_nettype wire

// *** tb/pbe_parity_handler_bench.sv ***
/*
  Self-checking bench for the parity handler: register access over
  AXI4-Lite, memory and transfer parity, traps and the self-test loop.
  Assumes the engine model stands beside the design on its start/done.
*/
`timescale 1ns/10ps
`default_nettype none

module pbe_parity_handler_bench;
  import pbe_pkg::*;
  localparam logic [15:0] TRAP_LOC = 16'h0040; // Arbitrary trap location.
  localparam logic [3:0]  ROUTINES = 4'd8;
  logic clk, rst, masterClear, memWrValid, memRdValid, xferValid;
  logic trapReq, stStart, stDone, stFail, cpuHold, irq, failNow;
  logic [15:0] memWrData, memRdData, trapAddr, xferGenData;
  pbe_word_t   memWrWord, memRdWord, xferWord, xferGenWord;
  logic [3:0]  stRoutine, panelId, wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic holdNf;
  int errCount, testsRun, cycles, launches, n0;
  logic [15:0] vals [4] = '{16'h0000, 16'hffff, 16'h0180, 16'h7f01};

  pbe_parity_handler #(.SELF_TEST_FITTED(1'b1), .NUM_ROUTINES(ROUTINES),
    .TRAP_ADDR(TRAP_LOC)) pbe_parity_handler_inst (
    .clk, .rst, .masterClear, .memWrValid, .memWrData, .memWrWord,
    .memRdValid, .memRdWord, .memRdData, .trapReq, .trapAddr,
    .xferValid, .xferWord, .xferGenData, .xferGenWord, .stStart,
    .stRoutine, .stDone, .stFail, .panelId, .cpuHold, .irq, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);

  // A handler built without self-test sees the same stimulus; no engine.
  pbe_parity_handler #(.SELF_TEST_FITTED(1'b0), .NUM_ROUTINES(ROUTINES),
    .TRAP_ADDR(TRAP_LOC)) pbe_parity_handler_nofit_inst (
    .clk, .rst, .masterClear, .memWrValid, .memWrData, .memWrWord(),
    .memRdValid, .memRdWord, .memRdData(), .trapReq(), .trapAddr(),
    .xferValid, .xferWord, .xferGenData, .xferGenWord(), .stStart(),
    .stRoutine(), .stDone(1'b0), .stFail(1'b0), .panelId(),
    .cpuHold(holdNf), .irq(), .awaddr, .awvalid, .awready(), .wdata,
    .wstrb, .wvalid, .wready(), .bresp(), .bvalid(), .bready, .araddr,
    .arvalid, .arready(), .rdata(), .rresp(), .rvalid(), .rready);

  pbe_engine_model pbe_engine_model_inst (.clk, .rst, .stStart,
    .stRoutine, .failNow, .failAt(4'h2), .stDone, .stFail);

  // Clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Launch counter and a ceiling well above the few hundred cycles used.
  always @(posedge clk) begin
    cycles++;
    if (stStart === 1'b1) launches++;
    if (cycles == 5000) begin
      errCount++;
      wrapUp();
    end
  end

  task wrapUp;
    $display("Checks %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrapUp

  task check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Address and data go out together and each drops once it is taken.
  task axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axiWr

  task axiRd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axiRd

  // Leaves the caller at the falling edge where the answer is settled.
  task memRead(input logic [17:0] w);
    @(posedge clk);
    memRdValid <= 1'b1;
    memRdWord <= w;
    @(posedge clk);
    memRdValid <= 1'b0;
    memRdWord <= ~w;
    @(negedge clk);
  endtask : memRead

  // An all-zero word is wrong in both bytes under odd parity.
  task procErr;
    @(posedge clk);
    xferValid <= 1'b1;
    xferWord <= 18'h0;
    @(posedge clk);
    xferValid <= 1'b0;
    xferWord <= 18'h2aaaa;
  endtask : procErr

  task waitHold(input logic lvl);
    for (int i = 0; i < 300 && cpuHold !== lvl; i++) @(negedge clk);
    check({31'h0, cpuHold}, {31'h0, lvl});
  endtask : waitHold

  function automatic logic [17:0] oddWord(input logic [15:0] d);
    return {~^d[15:8], d[15:8], ~^d[7:0], d[7:0]};
  endfunction : oddWord

  // Main sequence.
  initial begin
    {masterClear, memWrValid, memRdValid, xferValid, failNow} = 5'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {memWrData, xferGenData, awaddr, araddr, wdata} = '0;
    memRdWord = 18'h0;
    xferWord = 18'h0;
    wstrb = 4'hf;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axiRd(OFF_MASK);
    check(rd, {29'h0, MASK_RST});
    axiRd(OFF_FLAGS);
    check(rd, 32'h0);
    axiRd(8'h20);
    check({30'h0, resp}, {30'h0, RESP_ERR});
    axiWr(8'h20, 32'h1);
    check({30'h0, resp}, {30'h0, RESP_ERR});
    foreach (vals[i]) begin
      @(posedge clk);
      memWrValid <= 1'b1;
      memWrData <= vals[i];
      xferGenData <= vals[i];
      @(posedge clk);
      memWrValid <= 1'b0;
      @(negedge clk);
      check({14'h0, memWrWord}, {14'h0, oddWord(vals[i])});
      check({14'h0, xferGenWord}, {14'h0, oddWord(vals[i])});
    end
    // Check mode off: a bad read only raises the flag.
    memRead(oddWord(16'h00ff));
    check({31'h0, trapReq}, 32'h0);
    memRead(oddWord(16'h5a3c) ^ 18'h00100);
    check({31'h0, trapReq}, 32'h0);
    check({16'h0, memRdData}, 32'h5a3c);
    axiRd(OFF_FLAGS);
    check(rd, 32'h1);
    axiRd(OFF_STATUS);
    check(rd, 32'h0);
    axiWr(OFF_FLAGS, 32'h1);
    check({30'h0, resp}, {30'h0, RESP_OK});
    axiRd(OFF_FLAGS);
    check(rd, 32'h0);
    // Check mode on: trap pulse, status bit and interrupt.
    axiWr(OFF_CTRL, 32'h1);
    axiWr(OFF_MASK, 32'h1);
    memRead(oddWord(16'h1234) ^ 18'h20000);
    check({31'h0, trapReq}, 32'h1);
    check({16'h0, trapAddr}, {16'h0, TRAP_LOC});
    @(negedge clk);
    check({31'h0, trapReq}, 32'h0);
    check({31'h0, irq}, 32'h1);
    axiRd(OFF_STATUS);
    check(rd, 32'h1);
    axiRd(OFF_ERRW);
    check(rd, {14'h0, oddWord(16'h1234) ^ 18'h20000});
    axiWr(OFF_MASK, 32'h0);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    axiWr(OFF_MASK, 32'h1);
    axiWr(OFF_STATUS, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    // A processor error runs every routine once, then resumes.
    n0 = launches;
    procErr();
    waitHold(1'b1);
    check({31'h0, holdNf}, 32'h0);
    waitHold(1'b0);
    check(launches - n0, {28'h0, ROUTINES});
    axiRd(OFF_STATUS);
    check(rd, 32'h4);
    axiRd(OFF_FLAGS);
    check(rd, 32'h2);
    // Software start with routine 2 failing: stall, rerun, then resume.
    axiWr(OFF_STATUS, 32'h7);
    failNow <= 1'b1;
    n0 = launches;
    axiWr(OFF_CTRL, 32'h3);
    repeat (60) @(negedge clk);
    check({28'h0, panelId}, 32'h2);
    axiRd(OFF_STATE);
    check(rd & 32'hff1, 32'h221);
    check({31'h0, cpuHold}, 32'h1);
    check({31'h0, launches - n0 > 6}, 32'h1);
    axiRd(OFF_STATUS);
    check(rd, 32'h2);
    failNow <= 1'b0;
    waitHold(1'b0);
    axiRd(OFF_STATUS);
    check(rd, 32'h6);
    // Outside check mode a processor error starts nothing.
    axiWr(OFF_FLAGS, 32'h3);
    axiWr(OFF_CTRL, 32'h0);
    n0 = launches;
    procErr();
    repeat (5) @(negedge clk);
    check(launches - n0, 32'h0);
    axiRd(OFF_FLAGS);
    check(rd, 32'h2);
    // Master clear wipes the flags and starts self-test.
    @(posedge clk);
    masterClear <= 1'b1;
    @(posedge clk);
    masterClear <= 1'b0;
    waitHold(1'b1);
    axiRd(OFF_FLAGS);
    check(rd, 32'h0);
    waitHold(1'b0);
    wrapUp();
  end
endmodule : pbe_parity_handler_bench

`default_nettype wire
